/* lisd_regs.vh */
`ifndef LISD_REGS_VH
`define LISD_REGS_VH
// Control interface select code for hardware control mode
`define LISD_MODE_HW 2'h0
// Pulse template codes
`define LISD_PT_E1_75 4'h0
`define LISD_PT_E1_120 4'h1
`define LISD_PT_DSX1_LAST 4'h6
`define LISD_PT_J1 4'h7
`define LISD_PT_DS1_0DB 4'h8
`define LISD_PT_DS1_7P5 4'h9
`define LISD_PT_DS1_15 4'hA
`define LISD_PT_DS1_22P5 4'hB
// Line standard codes
`define LISD_STD_E1 2'h0
`define LISD_STD_DSX1 2'h1
`define LISD_STD_J1 2'h2
`define LISD_STD_DS1 2'h3
// Build-out codes for long haul
`define LISD_LBO_0DB 3'h0
`define LISD_LBO_7P5 3'h1
`define LISD_LBO_15 3'h2
`define LISD_LBO_22P5 3'h3
`define LISD_LBO_NONE 3'h4
// Matching impedance codes
`define LISD_IMP_75 2'h0
`define LISD_IMP_100 2'h1
`define LISD_IMP_110 2'h2
`define LISD_IMP_120 2'h3
// Transmit pattern codes
`define LISD_PAT_NORMAL 2'h0
`define LISD_PAT_ONES 2'h1
`define LISD_PAT_PSEUDO_RANDOM_SEQUENCE 2'h2
`define LISD_PAT_PDOWN 2'h3
// Jitter attenuator codes
`define LISD_JA_OFF 2'h0
`define LISD_JA_RX_BROAD 2'h1
`define LISD_JA_RX_NARROW 2'h2
`define LISD_JA_TX_NARROW 2'h3
`define LISD_FIFO_64 8'h40
`define LISD_FIFO_128 8'h80
`define LISD_FIFO_NONE 8'h00
// Loopback codes
`define LISD_LB_NONE 2'h0
`define LISD_LB_ANALOG 2'h1
`define LISD_LB_DIGITAL 2'h2
`define LISD_LB_REMOTE 2'h3
// Reset level of single-bit flags
`define LISD_RST_LOW 1'h0
`endif

/* lisd_strap_decoder.v */
`timescale 1ns/1ns
`default_nettype none
`include "lisd_regs.vh"

module lisd_strap_decoder (
  input wire sys_clk,
  input wire rst,
  input wire [1:0] interface_mode_select,
  input wire [3:0] pulse_template_select,
  input wire equalizer_range_select,
  input wire receiver_powerdown,
  input wire [1:0] transmit_pattern_select,
  input wire [1:0] jitter_attenuator_select,
  input wire monitor_gain_select,
  input wire [1:0] loopback_select,
  input wire driver_highz,
  input wire receive_clock_edge_select,
  output reg hw_mode_active_q,
  output reg [1:0] line_standard_q,
  output reg t1_rate_q,
  output reg [1:0] match_impedance_q,
  output reg long_haul_template_q,
  output reg [2:0] line_build_out_q,
  output reg eq_long_haul_q,
  output reg rx_powered_down_q,
  output reg tx_all_ones_q,
  output reg tx_pseudo_random_sequence_q,
  output reg tx_powered_down_q,
  output reg ja_enable_q,
  output reg ja_in_transmit_q,
  output reg ja_narrow_bw_q,
  output reg [7:0] ja_fifo_depth_q,
  output reg monitor_gain_high_q,
  output reg analog_loopback_q,
  output reg digital_loopback_q,
  output reg remote_loopback_q,
  output reg driver_enable_q,
  output reg rx_clock_falling_q
);

  // ****************************************
  // Template decode
  // ****************************************
  reg [1:0] std_d;
  reg [1:0] imp_d;
  reg [2:0] lbo_d;
  reg lh_d;
  reg hw_d;

  // Standard, impedance and build-out from template code
  always @* begin
    hw_d = (interface_mode_select == `LISD_MODE_HW);
    std_d = `LISD_STD_DS1;
    imp_d = `LISD_IMP_100;
    lbo_d = `LISD_LBO_NONE;
    lh_d = 1'h0;
    case (pulse_template_select)
      `LISD_PT_E1_75: begin
        std_d = `LISD_STD_E1;
        imp_d = `LISD_IMP_75;
      end
      `LISD_PT_E1_120: begin
        std_d = `LISD_STD_E1;
        imp_d = `LISD_IMP_120;
      end
      `LISD_PT_J1: begin
        std_d = `LISD_STD_J1;
        imp_d = `LISD_IMP_110;
      end
      `LISD_PT_DS1_0DB: begin
        lbo_d = `LISD_LBO_0DB;
        lh_d = 1'h1;
      end
      `LISD_PT_DS1_7P5: begin
        lbo_d = `LISD_LBO_7P5;
        lh_d = 1'h1;
      end
      `LISD_PT_DS1_15: begin
        lbo_d = `LISD_LBO_15;
        lh_d = 1'h1;
      end
      `LISD_PT_DS1_22P5: begin
        lbo_d = `LISD_LBO_22P5;
        lh_d = 1'h1;
      end
      default: begin
        if (pulse_template_select <= `LISD_PT_DSX1_LAST) begin
          std_d = `LISD_STD_DSX1;
        end else begin
          lh_d = 1'h1; // DS1, no build-out
        end
      end
    endcase
  end

  // ****************************************
  // Shared decode helpers
  // ****************************************

  // Select code to one-hot: 01, 10, 11 map to bits 0, 1, 2
  function [2:0] lisd_code_onehot;
    input [1:0] code;
    begin
      lisd_code_onehot = {(code == 2'h3), (code == 2'h2), (code == 2'h1)};
    end
  endfunction

  // Jitter attenuator FIFO depth in bits, zero when disabled
  function [7:0] lisd_fifo_depth;
    input [1:0] code;
    begin
      case (code)
        `LISD_JA_RX_BROAD: lisd_fifo_depth = `LISD_FIFO_64;
        `LISD_JA_RX_NARROW: lisd_fifo_depth = `LISD_FIFO_128;
        `LISD_JA_TX_NARROW: lisd_fifo_depth = `LISD_FIFO_128;
        default: lisd_fifo_depth = `LISD_FIFO_NONE;
      endcase
    end
  endfunction

  // Pattern and loopback selects share one encoding
  wire [2:0] pat_hot;
  wire [2:0] loop_hot;
  assign pat_hot = lisd_code_onehot(transmit_pattern_select);
  assign loop_hot = lisd_code_onehot(loopback_select);

  // ****************************************
  // Registered outputs
  // ****************************************

  // Mode flag follows the interface select on every edge
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hw_mode_active_q <= `LISD_RST_LOW;
    end else begin
      hw_mode_active_q <= hw_d;
    end
  end

  // Template outputs, held when not in hardware mode
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      line_standard_q <= `LISD_STD_E1;
      t1_rate_q <= `LISD_RST_LOW;
      match_impedance_q <= `LISD_IMP_75;
      long_haul_template_q <= `LISD_RST_LOW;
      line_build_out_q <= `LISD_LBO_NONE;
    end else if (hw_d) begin
      line_standard_q <= std_d;
      t1_rate_q <= (std_d != `LISD_STD_E1);
      match_impedance_q <= imp_d;
      long_haul_template_q <= lh_d;
      line_build_out_q <= lbo_d;
    end
  end

  // Receive side straps, held when not in hardware mode
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      eq_long_haul_q <= `LISD_RST_LOW;
      rx_powered_down_q <= `LISD_RST_LOW;
      monitor_gain_high_q <= `LISD_RST_LOW;
      rx_clock_falling_q <= `LISD_RST_LOW;
    end else if (hw_d) begin
      eq_long_haul_q <= equalizer_range_select;
      rx_powered_down_q <= receiver_powerdown;
      monitor_gain_high_q <= monitor_gain_select;
      rx_clock_falling_q <= receive_clock_edge_select;
    end
  end

  // Transmit source and line driver, driver off in reset
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_all_ones_q <= `LISD_RST_LOW;
      tx_pseudo_random_sequence_q <= `LISD_RST_LOW;
      tx_powered_down_q <= `LISD_RST_LOW;
      driver_enable_q <= `LISD_RST_LOW;
    end else if (hw_d) begin
      tx_all_ones_q <= pat_hot[0];
      tx_pseudo_random_sequence_q <= pat_hot[1];
      tx_powered_down_q <= pat_hot[2];
      driver_enable_q <= ~driver_highz;
    end
  end

  // Jitter attenuator position, bandwidth and depth
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ja_enable_q <= `LISD_RST_LOW;
      ja_in_transmit_q <= `LISD_RST_LOW;
      ja_narrow_bw_q <= `LISD_RST_LOW;
      ja_fifo_depth_q <= `LISD_FIFO_NONE;
    end else if (hw_d) begin
      ja_enable_q <= (jitter_attenuator_select != `LISD_JA_OFF);
      ja_in_transmit_q <= (jitter_attenuator_select == `LISD_JA_TX_NARROW);
      ja_narrow_bw_q <= jitter_attenuator_select[1];
      ja_fifo_depth_q <= lisd_fifo_depth(jitter_attenuator_select);
    end
  end

  // Loopback mode, one-hot
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      analog_loopback_q <= `LISD_RST_LOW;
      digital_loopback_q <= `LISD_RST_LOW;
      remote_loopback_q <= `LISD_RST_LOW;
    end else if (hw_d) begin
      analog_loopback_q <= loop_hot[0];
      digital_loopback_q <= loop_hot[1];
      remote_loopback_q <= loop_hot[2];
    end
  end

endmodule
`default_nettype wire

/* lisd_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// Decoder checker
// ****
module lisd_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] interface_mode_select,
  input wire logic [1:0] transmit_pattern_select,
  input wire logic [1:0] jitter_attenuator_select,
  input wire logic [1:0] loopback_select,
  input wire logic [3:0] pulse_template_select,
  input wire logic equalizer_range_select,
  input wire logic receiver_powerdown,
  input wire logic monitor_gain_select,
  input wire logic driver_highz,
  input wire logic receive_clock_edge_select,
  input wire logic hw_mode_active_q,
  input wire logic tx_all_ones_q,
  input wire logic tx_pseudo_random_sequence_q,
  input wire logic tx_powered_down_q,
  input wire logic ja_in_transmit_q,
  input wire logic [7:0] ja_fifo_depth_q,
  input wire logic analog_loopback_q,
  input wire logic digital_loopback_q,
  input wire logic remote_loopback_q,
  input wire logic [2:0] line_build_out_q,
  input wire logic eq_long_haul_q,
  input wire logic rx_powered_down_q,
  input wire logic monitor_gain_high_q,
  input wire logic driver_enable_q,
  input wire logic rx_clock_falling_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Hardware mode selected
  sequence s_hw;
    interface_mode_select == 2'h0;
  endsequence
  // Any other control interface selected
  sequence s_other;
    interface_mode_select != 2'h0;
  endsequence
  // Pin decode one cycle after sampling
  a_mode_on: assert property (s_hw |=> hw_mode_active_q) else $error("mode flag low");
  a_mode_off: assert property (s_other |=> !hw_mode_active_q && $stable(line_build_out_q))
    else $error("outputs not frozen");
  a_build_out: assert property (s_hw ##0 pulse_template_select[3] |=> line_build_out_q ==
    ($past(pulse_template_select[2]) ? 3'h4 : {1'b0, $past(pulse_template_select[1:0])}))
    else $error("build-out wrong");
  a_tx_source: assert property (s_hw |=> {tx_powered_down_q, tx_pseudo_random_sequence_q, tx_all_ones_q} ==
    (4'h1 << $past(transmit_pattern_select)) >> 1) else $error("pattern");
  a_loop_mode: assert property (s_hw |=> {remote_loopback_q, digital_loopback_q, analog_loopback_q} ==
    (4'h1 << $past(loopback_select)) >> 1) else $error("loopback");
  a_ja_depth: assert property (s_hw |=> ja_fifo_depth_q == ($past(jitter_attenuator_select) == 2'h0 ? 8'h00 :
    $past(jitter_attenuator_select) == 2'h1 ? 8'h40 : 8'h80) && ja_in_transmit_q == ($past(jitter_attenuator_select) == 2'h3))
    else $error("jitter");
  a_eq_range: assert property (s_hw |=> eq_long_haul_q == $past(equalizer_range_select)) else $error("eq");
  a_rx_down: assert property (s_hw |=> rx_powered_down_q == $past(receiver_powerdown)) else $error("rpd");
  a_mon_gain: assert property (s_hw |=> monitor_gain_high_q == $past(monitor_gain_select)) else $error("mon");
  a_drv_en: assert property (s_hw |=> driver_enable_q != $past(driver_highz)) else $error("driver");
  a_rx_edge: assert property (s_hw |=> rx_clock_falling_q == $past(receive_clock_edge_select)) else $error("edge");
endmodule
bind lisd_strap_decoder lisd_checker u_chk (.*);
`default_nettype wire

/* lisd_straps.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// Strap model
// ****
module lisd_straps (
  input wire logic sys_clk,
  output logic [16:0] pins
);
  // Straps move only at a falling edge, then hold
  initial pins = 17'h0;
  task put(input logic [16:0] v);
    @(negedge sys_clk) pins = v;
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// Decoder bench
// ****
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  wire [16:0] p;
  wire [31:0] o;
  int n_mismatch = 0;
  int num_checks = 0;
  int i;
  lisd_straps m (.sys_clk(sys_clk), .pins(p));
  lisd_strap_decoder dut (.sys_clk(sys_clk), .rst(rst), .interface_mode_select(p[16:15]),
    .pulse_template_select(p[14:11]), .equalizer_range_select(p[10]), .receiver_powerdown(p[9]),
    .transmit_pattern_select(p[8:7]), .jitter_attenuator_select(p[6:5]), .monitor_gain_select(p[4]),
    .loopback_select(p[3:2]), .driver_highz(p[1]), .receive_clock_edge_select(p[0]), .hw_mode_active_q(o[0]),
    .line_standard_q(o[2:1]), .t1_rate_q(o[3]), .match_impedance_q(o[5:4]), .long_haul_template_q(o[6]),
    .line_build_out_q(o[9:7]), .eq_long_haul_q(o[10]), .rx_powered_down_q(o[11]), .tx_all_ones_q(o[12]),
    .tx_pseudo_random_sequence_q(o[13]), .tx_powered_down_q(o[14]), .ja_enable_q(o[15]),
    .ja_in_transmit_q(o[16]), .ja_narrow_bw_q(o[17]), .ja_fifo_depth_q(o[25:18]), .monitor_gain_high_q(o[26]),
    .analog_loopback_q(o[27]), .digital_loopback_q(o[28]), .remote_loopback_q(o[29]),
    .driver_enable_q(o[30]), .rx_clock_falling_q(o[31]));
  // Clock
  initial forever #5 sys_clk = ~sys_clk;
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Apply straps and let one edge sample them
  task go(input logic [16:0] v);
    m.put(v);
    @(negedge sys_clk);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(negedge sys_clk);
    chk(o, 32'h200);
    rst = 1'b0;
    for (i = 0; i < 8; i++) begin
      go({2'h0, i[3:0], 11'h0});
      chk(o[9:0], (i == 0) ? 10'h201 : (i == 1) ? 10'h231 : (i == 7) ? 10'h22D : 10'h21B);
    end
    $display("short haul template test done");
    for (i = 8; i < 16; i++) begin
      go({2'h0, i[3:0], 11'h0});
      chk(o[9:0], {(i > 11) ? 3'h4 : {1'b0, i[1:0]}, 7'h5F});
    end
    $display("template test done");
    for (i = 0; i < 4; i++) begin
      go({6'h08, i[0], i[1], i[1:0], i[1:0], i[0], i[1:0], i[1], i[0]});
      chk(o[14:12], (1 << i) >> 1);
      chk(o[29:27], (1 << i) >> 1);
      chk(o[25:15], {(i == 0) ? 8'h0 : (i == 1) ? 8'h40 : 8'h80, i[1], i == 3, i != 0});
      chk({o[31:30], o[26], o[11:10]}, {i[0], !i[1], i[0], i[1], i[0]});
    end
    $display("code test done");
    for (i = 1; i < 4; i++) begin
      go({i[1:0], 15'h7FFF});
      chk(o, 32'hA603CC5E);
    end
    $display("freeze test done");
    summarize;
  end
endmodule
`default_nettype wire
